// ### inc/i2ctd_regs.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 I2C timing and datapath register slice. Assumes inclusion by bare name.
*/
`ifndef I2CTD_REGS_SVH
`define I2CTD_REGS_SVH

`define I2CTD_ADDR_W          8
`define I2CTD_OFS_CLK_HIGH    8'h18
`define I2CTD_OFS_CLK_LOW     8'h19
`define I2CTD_OFS_DP_CTRL2    8'h1A
`define I2CTD_OFS_BC_ERRORS   8'h1B
`define I2CTD_OFS_BUILT_IN_SELF_TEST_CLEAR  8'h04
`define I2CTD_OFS_PORT_SEL    8'h1E
`define I2CTD_OFS_IRQ_STATUS  8'h20
`define I2CTD_OFS_IRQ_MASK    8'h21
`define I2CTD_RST_CLK_HIGH    8'h7F
`define I2CTD_RST_CLK_LOW     8'h7F
`define I2CTD_RST_DP_CTRL2    8'h01
`define I2CTD_BIT_SURROUND    0
`define I2CTD_BIT_WIDE        1
`define I2CTD_BIT_AUX_AUDIO   3
`define I2CTD_BIT_BUILT_IN_SELF_TEST_CLEAR  5
`define I2CTD_BIT_PORT_SEL    0
`define I2CTD_EXTRA_PERIODS   8'h05
`define I2CTD_ERR_SAT         8'hFF
`define I2CTD_IRQ_SAT0        0
`define I2CTD_IRQ_SAT1        1
`define I2CTD_IRQ_SCL         2
`define I2CTD_IRQ_W           3

`endif

// ### inc/i2ctd_pkg.sv
/*
 Types shared by the register slice and its clock generator.
 Assumes the register header is compiled alongside.
*/
package i2ctd_pkg;
	typedef enum logic [1:0] {
		I2CTD_IDLE,
		I2CTD_HIGH,
		I2CTD_LOW,
		I2CTD_SETUP
	} i2ctd_phase_t;
	typedef logic [7:0] i2ctd_byte_t;
endpackage

// ### inc/i2ctd_clk_if.sv
/*
 Interface between the register slice and the clock pulse generator.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
interface i2ctd_clk_if;
	import i2ctd_pkg::*;
	i2ctd_byte_t high_width;
	i2ctd_byte_t low_width;
	logic        run_master;
	logic        run_setup;
	logic        scl_level;
	logic        setup_done;
	logic        period_done;
	modport ctrl (output high_width, output low_width, output run_master, output run_setup,
		input scl_level, input setup_done, input period_done);
	modport gen (input high_width, input low_width, input run_master, input run_setup,
		output scl_level, output setup_done, output period_done);
endinterface
`default_nettype wire

// ### rtl/i2ctd_clk_gen.sv
/*
 Clock pulse generator: high and low phases of the local master clock and
 the data setup interval of the slave before the stretched clock is released.
 Assumes one clock and a clock enable shared with the register slice.
*/
`timescale 1ns/100ps
`default_nettype none
`include "i2ctd_regs.svh"
module i2ctd_clk_gen (
	input  wire logic  clk_sys,
	input  wire logic  rst_n,
	input  wire logic  clk_en,
	i2ctd_clk_if.gen   bus
);
	import i2ctd_pkg::*;

	i2ctd_phase_t phase;
	logic [8:0]   count;
	logic [8:0]   high_len;
	logic [8:0]   low_len;
	wire          count_end;

	// Field plus fixed extra periods; nine bits hold 255 + 5
	assign high_len  = {1'b0, bus.high_width} + {1'b0, `I2CTD_EXTRA_PERIODS}; // RULE2
	assign low_len   = {1'b0, bus.low_width} + {1'b0, `I2CTD_EXTRA_PERIODS};  // RULE3
	assign count_end = (count == 9'h001);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase           <= I2CTD_IDLE;
			count           <= 9'h000;
			bus.scl_level   <= 1'b1;
			bus.setup_done  <= 1'b0;
			bus.period_done <= 1'b0;
		end else if (clk_en) begin
			bus.setup_done  <= 1'b0;
			bus.period_done <= 1'b0;
			case (phase)
				I2CTD_IDLE: begin
					bus.scl_level <= 1'b1;
					if (bus.run_setup) begin
						phase <= I2CTD_SETUP;
						count <= low_len; // RULE4
					end else if (bus.run_master) begin
						phase <= I2CTD_HIGH;
						count <= high_len; // RULE1
					end
				end
				I2CTD_HIGH: begin
					bus.scl_level <= 1'b1;
					if (count_end) begin
						phase <= I2CTD_LOW;
						count <= low_len; // RULE3
					end else begin
						count <= count - 9'h001;
					end
				end
				I2CTD_LOW: begin
					bus.scl_level <= 1'b0;
					if (count_end) begin
						bus.period_done <= 1'b1;
						phase <= bus.run_master ? I2CTD_HIGH : I2CTD_IDLE;
						count <= high_len;
					end else begin
						count <= count - 9'h001;
					end
				end
				I2CTD_SETUP: begin
					// Clock held low by the slave until the data has stood long enough
					bus.scl_level <= 1'b0;
					if (count_end) begin
						bus.setup_done <= 1'b1; // RULE4
						phase <= I2CTD_IDLE;
					end else begin
						count <= count - 9'h001;
					end
				end
				default: phase <= I2CTD_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### rtl/i2ctd_regs.sv
/*
 Register slice 0x18..0x1B: master clock widths, datapath control and the
 self-test back-channel error counter, plus port select, irq status and mask.
 Assumes a plain register port on clk_sys and error pulses already in clk_sys.
*/
// Our own choice: strobed register access.
// Function
// RULE1: The master clock high width comes from an 8-bit field that resets to 0x7F.
// RULE2: The high phase lasts the field value plus five oscillator periods.
// RULE3: The low phase comes from its own 8-bit field plus five periods, reset 0x7F.
// RULE4: As slave the data stands for the low-width interval before the clock is released.
// RULE5: The wide payload bit selects 28-bit data when set, 24-bit plus syncs when clear.
// RULE6: The surround bit selects 5.1 or 7.1 audio when set, else 2 or 4 channel audio.
// RULE7: Surround audio travels only through data-island transport.
// RULE8: In a repeater the detected in-band audio mode may override the surround bit.
// RULE9: Back-channel CRC errors count in self-test mode in 8 bits saturating at 255.
// RULE10: The error counter clears on a new self-test start or a write of bit 5 at 0x04.
// RULE11: With the port select bit set, the counter read returns the second port's count.
// RULE12: Reserved bits read as zero and writes to them do nothing.
`timescale 1ns/100ps
`default_nettype none
`include "i2ctd_regs.svh"
module i2ctd_regs #(
	parameter int PORTS = 2
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic                      clk_en,
	input  wire logic [`I2CTD_ADDR_W-1:0]  reg_addr,
	input  wire i2ctd_pkg::i2ctd_byte_t    reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output i2ctd_pkg::i2ctd_byte_t         reg_rdata,
	input  wire logic                      aux_audio_strap,
	input  wire logic                      repeater_mode,
	input  wire logic                      inband_surround,
	input  wire logic                      built_in_self_test,
	input  wire logic [PORTS-1:0]          back_channel_crc_err,
	input  wire logic                      master_start,
	input  wire logic                      slave_setup_req,
	output logic                           master_scl,
	output logic                           slave_release,
	output logic                           wide_payload_select,
	output logic                           surround_audio,
	output logic                           data_island_audio,
	output logic                           irq
);
	import i2ctd_pkg::*;

	// Reset image of the datapath control byte, split into its bits below
	localparam i2ctd_byte_t dp_reset = `I2CTD_RST_DP_CTRL2;

	i2ctd_clk_if clk_bus ();

	i2ctd_byte_t master_clock_high_width;
	i2ctd_byte_t master_clock_low_width;
	logic        wide_bit;
	logic        surround_bit;
	logic        second_port_view;
	logic [`I2CTD_IRQ_W-1:0] irq_status;
	logic [`I2CTD_IRQ_W-1:0] irq_mask;
	i2ctd_byte_t err_count [PORTS];
	logic        built_in_self_test_q;
	logic        aux_s1;
	logic        aux_s2;
	logic        aux_s3;
	logic        aux_audio;

	wire hit_high   = (reg_addr == `I2CTD_OFS_CLK_HIGH);
	wire hit_low    = (reg_addr == `I2CTD_OFS_CLK_LOW);
	wire hit_dp     = (reg_addr == `I2CTD_OFS_DP_CTRL2);
	wire hit_err    = (reg_addr == `I2CTD_OFS_BC_ERRORS);
	wire hit_clear  = (reg_addr == `I2CTD_OFS_BUILT_IN_SELF_TEST_CLEAR);
	wire hit_port   = (reg_addr == `I2CTD_OFS_PORT_SEL);
	wire hit_status = (reg_addr == `I2CTD_OFS_IRQ_STATUS);
	wire hit_mask   = (reg_addr == `I2CTD_OFS_IRQ_MASK);
	// Self-test start is the rising edge of the enable, a same-clock level
	wire built_in_self_test_start = built_in_self_test && !built_in_self_test_q;
	wire sw_clear   = reg_wr && hit_clear && reg_wdata[`I2CTD_BIT_BUILT_IN_SELF_TEST_CLEAR];
	wire err_clear  = built_in_self_test_start || sw_clear; // RULE10
	wire surround_eff = repeater_mode ? inband_surround : surround_bit; // RULE8
	wire [PORTS-1:0] sat_event;
	wire [`I2CTD_IRQ_W-1:0] irq_event;
	wire i2ctd_byte_t err_view = second_port_view ? err_count[PORTS-1] : err_count[0]; // RULE11
	i2ctd_byte_t read_mux;

	always_comb begin
		if (hit_high) begin
			read_mux = master_clock_high_width;
		end else if (hit_low) begin
			read_mux = master_clock_low_width;
		end else if (hit_dp) begin
			// Bits 7:4 and 2 reserved, read zero
			read_mux = {4'h0, aux_audio, 1'b0, wide_bit, surround_bit}; // RULE12
		end else if (hit_err) begin
			read_mux = err_view;
		end else if (hit_port) begin
			read_mux = {7'h00, second_port_view};
		end else if (hit_status) begin
			read_mux = {5'h00, irq_status};
		end else if (hit_mask) begin
			read_mux = {5'h00, irq_mask};
		end else begin
			read_mux = 8'h00;
		end
	end

	// Strap passes three flops; a change counts once the last two agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aux_s1    <= 1'b0;
			aux_s2    <= 1'b0;
			aux_s3    <= 1'b0;
			aux_audio <= 1'b0;
		end else if (clk_en) begin
			aux_s1 <= aux_audio_strap;
			aux_s2 <= aux_s1;
			aux_s3 <= aux_s2;
			if (aux_s2 == aux_s3) begin
				aux_audio <= aux_s3;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			master_clock_high_width <= `I2CTD_RST_CLK_HIGH; // RULE1
			master_clock_low_width  <= `I2CTD_RST_CLK_LOW;  // RULE3
			wide_bit                <= dp_reset[`I2CTD_BIT_WIDE];
			surround_bit            <= dp_reset[`I2CTD_BIT_SURROUND];
			second_port_view        <= 1'b0;
			irq_mask                <= '0;
		end else if (clk_en && reg_wr) begin
			if (hit_high) begin
				master_clock_high_width <= reg_wdata;
			end else if (hit_low) begin
				master_clock_low_width <= reg_wdata;
			end else if (hit_dp) begin
				wide_bit     <= reg_wdata[`I2CTD_BIT_WIDE];     // RULE5
				surround_bit <= reg_wdata[`I2CTD_BIT_SURROUND]; // RULE6
			end else if (hit_port) begin
				second_port_view <= reg_wdata[`I2CTD_BIT_PORT_SEL];
			end else if (hit_mask) begin
				irq_mask <= reg_wdata[`I2CTD_IRQ_W-1:0];
			end
		end
	end

	genvar p;
	generate
		for (p = 0; p < PORTS; p++) begin : g_port
			assign sat_event[p] = built_in_self_test && back_channel_crc_err[p]
				&& !err_clear && (err_count[p] == `I2CTD_ERR_SAT - 8'h01);
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					err_count[p] <= 8'h00;
				end else if (clk_en) begin
					if (err_clear) begin
						err_count[p] <= 8'h00; // RULE10
					end else if (built_in_self_test && back_channel_crc_err[p]
						&& err_count[p] != `I2CTD_ERR_SAT) begin
						// Saturate instead of wrap so a long run never looks clean
						err_count[p] <= err_count[p] + 8'h01; // RULE9
					end
				end
			end
		end
	endgenerate

	assign irq_event = {clk_bus.period_done, sat_event[PORTS-1], sat_event[0]};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
			built_in_self_test_q     <= 1'b0;
		end else if (clk_en) begin
			built_in_self_test_q <= built_in_self_test;
			// A new event wins over a write-one clear in the same cycle
			irq_status <= (irq_status & ~((reg_wr && hit_status) ?
				reg_wdata[`I2CTD_IRQ_W-1:0] : '0)) | irq_event;
		end
	end

	assign clk_bus.high_width = master_clock_high_width;
	assign clk_bus.low_width  = master_clock_low_width;
	assign clk_bus.run_master = master_start;
	assign clk_bus.run_setup  = slave_setup_req;

	i2ctd_clk_gen u_clk_gen (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.bus     (clk_bus.gen)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata           <= 8'h00;
			master_scl          <= 1'b1;
			slave_release       <= 1'b0;
			wide_payload_select <= 1'b0;
			surround_audio      <= 1'b0;
			data_island_audio   <= 1'b0;
			irq                 <= 1'b0;
		end else if (clk_en) begin
			reg_rdata           <= reg_rd ? read_mux : 8'h00;
			master_scl          <= clk_bus.scl_level; // RULE1
			slave_release       <= clk_bus.setup_done; // RULE4
			wide_payload_select <= wide_bit; // RULE5
			surround_audio      <= surround_eff; // RULE6
			// Surround has no path but the data island
			data_island_audio   <= surround_eff; // RULE7
			irq                 <= |(irq_status & irq_mask);
		end
	end
endmodule
`default_nettype wire

// ### testbench/i2ctd_regs_sva.sv
/*
 Checker for the register slice top: read port, datapath outputs, master clock and irq.
 Assumes it is bound onto i2ctd_regs and that clk_en stays high during clock phases.
*/
`timescale 1ns/100ps
`default_nettype none
module i2ctd_regs_sva (
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	input wire logic                   clk_en,
	input wire logic [7:0]             reg_addr,
	input wire i2ctd_pkg::i2ctd_byte_t reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire i2ctd_pkg::i2ctd_byte_t reg_rdata,
	input wire logic                   repeater_mode,
	input wire logic                   inband_surround,
	input wire logic                   master_start,
	input wire logic                   master_scl,
	input wire logic                   slave_release,
	input wire logic                   wide_payload_select,
	input wire logic                   surround_audio,
	input wire logic                   data_island_audio,
	input wire logic                   irq
);
	import i2ctd_pkg::*;
	i2ctd_byte_t hi_w;
	i2ctd_byte_t lo_w;
	logic [8:0]  run_len;
	logic        scl_d;
	logic        seen_r;
	logic        seen_f;
	wire         wr_hi = reg_wr && clk_en && reg_addr == 8'h18;
	wire         wr_lo = reg_wr && clk_en && reg_addr == 8'h19;
	// Shadow widths; a width change in mid-phase is not modelled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hi_w <= 8'h7F;
			lo_w <= 8'h7F;
			scl_d <= 1'b1;
			run_len <= 9'h000;
			seen_r <= 1'b0;
			seen_f <= 1'b0;
		end else begin
			hi_w <= wr_hi ? reg_wdata : hi_w;
			lo_w <= wr_lo ? reg_wdata : lo_w;
			scl_d <= master_scl;
			run_len <= (master_scl != scl_d) ? 9'h001 : run_len + 9'h001;
			seen_r <= master_start && (seen_r || (master_scl && !scl_d));
			seen_f <= master_start && (seen_f || (!master_scl && scl_d));
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_rd_idle; !reg_rd && clk_en |=> reg_rdata == 8'h00; endproperty
	property p_unmapped; reg_rd && clk_en && !(reg_addr inside {8'h04, 8'h18, 8'h19, 8'h1A,
		8'h1B, 8'h1E, 8'h20, 8'h21}) |=> reg_rdata == 8'h00; endproperty
	property p_dp_resv; reg_rd && clk_en && reg_addr == 8'h1A |=> (reg_rdata & 8'hF4) == 8'h00;
	endproperty
	property p_ps_resv; reg_rd && clk_en && reg_addr == 8'h1E |=> (reg_rdata & 8'hFE) == 8'h00;
	endproperty
	property p_wide; reg_wr && clk_en && reg_addr == 8'h1A ##1 clk_en
		|=> wide_payload_select == $past(reg_wdata[1], 2); endproperty
	property p_surr; reg_wr && clk_en && reg_addr == 8'h1A && !repeater_mode ##1
		clk_en && !repeater_mode |=> surround_audio == $past(reg_wdata[0], 2); endproperty
	property p_rep; repeater_mode && clk_en |=> surround_audio == $past(inband_surround);
	endproperty
	property p_island; data_island_audio == surround_audio; endproperty
	property p_mask; reg_wr && clk_en && reg_addr == 8'h21 && reg_wdata == 8'h00 ##1
		clk_en && !(reg_wr && reg_addr == 8'h21) |=> !irq; endproperty
	property p_high; $fell(master_scl) && seen_r |-> run_len == {1'b0, hi_w} + 9'h005;
	endproperty
	property p_low; $rose(master_scl) && seen_f |-> run_len == {1'b0, lo_w} + 9'h005;
	endproperty
	property p_rel; slave_release |=> !slave_release; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_dp_resv: assert property (p_dp_resv) else $error("datapath reserved bits set");
	a_ps_resv: assert property (p_ps_resv) else $error("port reserved bits set");
	a_wide: assert property (p_wide) else $error("payload select mismatch");
	a_surr: assert property (p_surr) else $error("surround select mismatch");
	a_rep: assert property (p_rep) else $error("repeater override mismatch");
	a_island: assert property (p_island) else $error("island transport mismatch");
	a_mask: assert property (p_mask) else $error("irq high while masked");
	a_high: assert property (p_high) else $error("clock high phase length");
	a_low: assert property (p_low) else $error("clock low phase length");
	a_rel: assert property (p_rel) else $error("release wider than a cycle");
	c_high: cover property ($fell(master_scl) && seen_r);
	c_rel: cover property (slave_release);
	c_irq: cover property ($rose(irq));
endmodule
bind i2ctd_regs i2ctd_regs_sva u_sva (.clk_sys, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .repeater_mode, .inband_surround, .master_start, .master_scl,
	.slave_release, .wide_payload_select, .surround_audio, .data_island_audio, .irq);
`default_nettype wire

// ### testbench/i2ctd_regs_bench.sv
/*
 Self-checking bench for the register slice: registers, datapath outputs, master clock,
 slave setup, self-test error counters and irq. Assumes the checker binds itself.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) chk(n, e, g)
module i2ctd_regs_bench;
	import i2ctd_pkg::*;
	logic        clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	i2ctd_byte_t reg_wdata = 8'h00, reg_rdata, d;
	logic        aux_audio_strap = 1'b1, repeater_mode = 1'b0, inband_surround = 1'b0;
	logic        built_in_self_test = 1'b0, master_start = 1'b0, slave_setup_req = 1'b0;
	logic [1:0]  back_channel_crc_err = 2'b00;
	logic        master_scl, slave_release, wide_payload_select, surround_audio;
	logic        data_island_audio, irq;
	int          err_total = 0, num_checks = 0, n;
	always #50 clk_sys = ~clk_sys;
	i2ctd_regs u_dut (.clk_sys, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .aux_audio_strap, .repeater_mode, .inband_surround, .built_in_self_test,
		.back_channel_crc_err, .master_start, .slave_setup_req, .master_scl, .slave_release,
		.wide_payload_select, .surround_audio, .data_island_audio, .irq);
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data stand in one cycle only, so they are taken mid-cycle
	task automatic rd(logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic rchk(string s, logic [7:0] a, logic [7:0] e);
		rd(a);
		`CHK(s, e, d);
	endtask
	task automatic settle;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic pulse(logic [1:0] p);
		@(posedge clk_sys);
		back_channel_crc_err <= p;
		@(posedge clk_sys);
		back_channel_crc_err <= 2'b00;
	endtask
	task automatic phase(logic lvl);
		n = 0;
		while (master_scl === lvl && n < 300) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 300) begin
			`CHK("clock phase timeout", 1, 0);
			test_done;
		end
	endtask
	task automatic t_regs;
		rchk("high width", 8'h18, 8'h7F);
		rchk("low width", 8'h19, 8'h7F);
		rchk("dp ctrl", 8'h1A, 8'h09);
		rchk("unmapped", 8'h55, 8'h00);
		`CHK("wide", 1'b0, wide_payload_select);
		wr(8'h1A, 8'hFF);
		settle;
		`CHK("wide", 1'b1, wide_payload_select);
		`CHK("surround", 1'b1, surround_audio);
		rchk("dp ctrl", 8'h1A, 8'h0B);
		@(posedge clk_sys);
		aux_audio_strap <= 1'b0;
		wr(8'h1A, 8'h00);
		settle;
		`CHK("wide", 1'b0, wide_payload_select);
		`CHK("island", 1'b0, data_island_audio);
		rchk("dp ctrl", 8'h1A, 8'h00);
		wr(8'h1B, 8'h55);
		rchk("errors ro", 8'h1B, 8'h00);
		wr(8'h1E, 8'hFE);
		rchk("port sel", 8'h1E, 8'h00);
		wr(8'h33, 8'hFF);
		rchk("unmapped", 8'h33, 8'h00);
	endtask
	task automatic t_rep;
		@(posedge clk_sys);
		repeater_mode <= 1'b1;
		inband_surround <= 1'b1;
		settle;
		`CHK("repeater on", 1'b1, surround_audio);
		@(posedge clk_sys);
		inband_surround <= 1'b0;
		wr(8'h1A, 8'h01);
		settle;
		`CHK("repeater off", 1'b0, surround_audio);
		@(posedge clk_sys);
		repeater_mode <= 1'b0;
		settle;
		`CHK("surround bit", 1'b1, data_island_audio);
	endtask
	task automatic t_clock;
		wr(8'h21, 8'h04);
		wr(8'h18, 8'h02);
		wr(8'h19, 8'h03);
		@(posedge clk_sys);
		master_start <= 1'b1;
		phase(1'b1);
		phase(1'b0);
		`CHK("low phase", 16'd8, n);
		phase(1'b1);
		`CHK("high phase", 16'd7, n);
		@(posedge clk_sys);
		master_start <= 1'b0;
		settle;
		`CHK("irq period", 1'b1, irq);
		wr(8'h21, 8'h00);
		settle;
		`CHK("irq masked", 1'b0, irq);
		wr(8'h21, 8'h04);
		wr(8'h20, 8'h04);
		settle;
		`CHK("irq cleared", 1'b0, irq);
	endtask
	task automatic t_setup;
		@(posedge clk_sys);
		slave_setup_req <= 1'b1;
		@(posedge clk_sys);
		slave_setup_req <= 1'b0;
		n = 0;
		while (slave_release !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("setup time", 1'b1, n >= 8 && n <= 12);
		if (n >= 100) begin
			test_done;
		end
	endtask
	// A write while the enable is low must leave the register untouched
	task automatic t_freeze;
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(8'h18, 8'h11);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		rchk("frozen write", 8'h18, 8'h02);
	endtask
	task automatic t_errors;
		@(posedge clk_sys);
		built_in_self_test <= 1'b1;
		@(posedge clk_sys);
		pulse(2'b11);
		pulse(2'b11);
		pulse(2'b01);
		@(posedge clk_sys);
		built_in_self_test <= 1'b0;
		@(posedge clk_sys);
		pulse(2'b11);
		rchk("port0 count", 8'h1B, 8'h03);
		wr(8'h1E, 8'h01);
		rchk("port1 count", 8'h1B, 8'h02);
		wr(8'h04, 8'h20);
		rchk("sw clear", 8'h1B, 8'h00);
		@(posedge clk_sys);
		built_in_self_test <= 1'b1;
		@(posedge clk_sys);
		pulse(2'b10);
		rchk("port1 count", 8'h1B, 8'h01);
		@(posedge clk_sys);
		built_in_self_test <= 1'b0;
		@(posedge clk_sys);
		built_in_self_test <= 1'b1;
		rchk("restart clear", 8'h1B, 8'h00);
		wr(8'h1E, 8'h00);
		repeat (260) pulse(2'b01);
		rchk("saturated", 8'h1B, 8'hFF);
		rd(8'h20);
		`CHK("sat status", 1'b1, d[0]);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_regs;
		t_rep;
		t_clock;
		t_setup;
		t_freeze;
		t_errors;
		test_done;
	end
endmodule
`default_nettype wire
